// >>> msac_regs.svh
// Constants for the multichannel SAR ADC control block
`ifndef MSAC_REGS_SVH
`define MSAC_REGS_SVH
`define MSAC_CLK_MHZ 20
`define MSAC_NS_PER_US 1000
`define MSAC_T_CONV_NS 4000
`define MSAC_T_ACQ_NS 4000
`define MSAC_T_THRU_NS 10000
`define MSAC_T_STRB_NS 40
`define MSAC_CONV_CYC ((`MSAC_T_CONV_NS * `MSAC_CLK_MHZ) / `MSAC_NS_PER_US)
`define MSAC_STRB_CYC \
  (((`MSAC_T_STRB_NS * `MSAC_CLK_MHZ) + `MSAC_NS_PER_US - 1) / `MSAC_NS_PER_US)
`define MSAC_RES_W 16
`define MSAC_RES_DEF 16
`define MSAC_CFG_W 8
`define MSAC_FRAME 16
`define MSAC_ACQ_EDGE 6
`define MSAC_CFG_SGL 7
`define MSAC_CFG_ODD 6
`define MSAC_CFG_SEL 4
`define MSAC_CFG_UNI 3
`define MSAC_CFG_SPAN 2
`define MSAC_CFG_NAP 1
`define MSAC_CFG_SLEEP 0
`define MSAC_CFG_RST 8'h00
`define MSAC_RESULT_RST 16'h0000
`endif

// >>> msac_pkg.sv
// Types for the multichannel SAR ADC control block
`default_nettype none
package msac_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_acq  = 2'h1,
    st_conv = 2'h3
  } msac_state_t;
endpackage
`default_nettype wire

// >>> msac_sar_if.sv
// Carrier between the conversion sequencer and the SAR engine
`timescale 1ns/1ps
`default_nettype none
`include "msac_regs.svh"
interface msac_sar_if;
  logic                   start;
  logic                   decide;
  logic                   done;
  logic                   busy;
  logic [`MSAC_RES_W-1:0] trial;
  logic [`MSAC_RES_W-1:0] result;
  modport ctrl (output start, output decide, input done, input busy,
                input trial, input result);
  modport eng  (input start, input decide, output done, output busy,
                output trial, output result);
endinterface
`default_nettype wire

// >>> msac_sync.sv
// Two-flop synchroniser, one chain per bit
`timescale 1ns/1ps
`default_nettype none
module msac_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  generate
    for (genvar g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          meta_reg[g] <= RST[g];
          q_reg[g]    <= RST[g];
        end
        else
        begin
          meta_reg[g] <= i_d[g];
          q_reg[g]    <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign o_q = q_reg;
endmodule
`default_nettype wire

// >>> msac_sar.sv
// Successive-approximation engine, one comparator decision per bit
`timescale 1ns/1ps
`default_nettype none
`include "msac_regs.svh"
module msac_sar #(
  parameter int RES     = `MSAC_RES_DEF,
  parameter int BIT_CYC = `MSAC_CONV_CYC / `MSAC_RES_W
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Sequencer side
  msac_sar_if.eng   s
);
  localparam int W  = `MSAC_RES_W;
  localparam int IW = $clog2(W);
  localparam int CW = $clog2(BIT_CYC + 1);

  generate
    if (!(RES == 12 || RES == 14 || RES == 16) || BIT_CYC < 3)
    begin : g_bad
      $error("msac_sar: unsupported resolution or bit time");
    end
  endgenerate

  logic [W-1:0]  sar_reg;
  logic [W-1:0]  res_reg;
  logic [IW-1:0] idx_reg;
  logic [CW-1:0] cyc_reg;
  logic          busy_reg;
  logic          done_reg;

  wire logic         bit_end  = busy_reg && (cyc_reg == CW'(BIT_CYC - 1));
  wire logic         last_bit = idx_reg == IW'(W - RES);
  wire logic         launch   = s.start && !busy_reg;
  wire logic [W-1:0] one_hot  = W'(1) << idx_reg;
  wire logic [W-1:0] kept     = s.decide ? sar_reg : (sar_reg & ~one_hot);
  wire logic [W-1:0] trial_nx = kept | (one_hot >> 1);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      busy_reg <= 1'b0;
    else if (launch)
      busy_reg <= 1'b1;
    else if (bit_end && last_bit)
      busy_reg <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cyc_reg <= '0;
    else if (launch || bit_end)
      cyc_reg <= '0;
    else if (busy_reg)
      cyc_reg <= cyc_reg + CW'(1);
  end

  // MSB trial first, each decision keeps or drops one bit
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sar_reg <= `MSAC_RESULT_RST;
      idx_reg <= '0;
    end
    else if (launch)
    begin
      sar_reg <= W'(1) << (W - 1);
      idx_reg <= IW'(W - 1);
    end
    else if (bit_end && !last_bit)
    begin
      sar_reg <= trial_nx;
      idx_reg <= idx_reg - IW'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      res_reg <= `MSAC_RESULT_RST;
    else if (bit_end && last_bit)
      res_reg <= kept;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      done_reg <= 1'b0;
    else
      done_reg <= bit_end && last_bit;
  end

  assign s.busy   = busy_reg;
  assign s.done   = done_reg;
  assign s.trial  = sar_reg;
  assign s.result = res_reg;

  a_msb_first: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    launch |=> s.trial == (W'(1) << (W - 1)) ##(BIT_CYC - 1) idx_reg == IW'(W - 1))
    else $error("first trial is not the MSB alone");
  a_one_per_bit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    bit_end && !last_bit |=> idx_reg == $past(idx_reg) - IW'(1))
    else $error("SAR did not step down one bit");
endmodule
`default_nettype wire

// >>> msac_top.sv
// Control and serial link of an eight-channel SAR ADC
//
// What this block does
// - Host shifts 8-bit configuration on first rises
// - Acquisition starts on sixth falling shift edge
// - Strobe rise ends acquisition, holds, converts
// - Strobes ignored while a conversion runs
// - SAR resolves MSB to LSB, one decision
// - End of conversion loads result shift register
// - Internal clock times conversion, about 4 us
// - Acquisition plus conversion supports 100 ksps
// - Bipolar gives two's complement, unipolar straight binary
// - Busy low during conversion, high afterwards
// - Lower resolutions shift out trailing zero bits
// - Read tied low: output always driven
// - Strobe tied to read: output floats high
// - Read low after busy drives previous result
// - Data changes on falling, sampled on rising
// - Result shifts out during next configuration word
// - Word: mux code, unipolar, span, nap, sleep
`timescale 1ns/1ps
`default_nettype none
`include "msac_regs.svh"
module msac_top #(
  parameter int RES = `MSAC_RES_DEF
) (
  // System clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Serial link
  input  wire logic        i_sck,
  input  wire logic        i_serial_config_in,
  input  wire logic        i_conversion_start_strobe,
  input  wire logic        i_read_n,
  output logic             o_serial_result_out,
  output logic             o_serial_result_out_oe,
  output logic             o_busy_n,
  // Analog front end
  input  wire logic        i_comparator,
  output logic      [15:0] o_dac_trial,
  output logic             o_sample_hold_track,
  output logic             o_mux_single_ended,
  output logic             o_mux_odd_sign,
  output logic      [1:0]  o_mux_select,
  output logic             o_unipolar_select,
  output logic             o_span_double,
  output logic             o_nap_req,
  output logic             o_sleep_req
);
  localparam int W       = `MSAC_RES_W;
  localparam int CFG     = `MSAC_CFG_W;
  localparam int FRAME   = `MSAC_FRAME;
  localparam int BIT_CYC = `MSAC_CONV_CYC / W;
  localparam int CONV_LO = RES * BIT_CYC + 1;
  localparam int FW      = $clog2(FRAME);

  // Throughput budget checked at elaboration
  generate
    if (`MSAC_T_ACQ_NS + `MSAC_T_CONV_NS > `MSAC_T_THRU_NS)
    begin : g_thru
      $error("msac_top: acquisition plus conversion exceeds throughput");
    end
    if (`MSAC_STRB_CYC > 1)
    begin : g_strb
      $error("msac_top: strobe shorter than the sampling clock needs");
    end
  endgenerate

  // ---------------- Link clock domain ----------------
  logic [FW-1:0]  rise_cnt_reg;
  logic [FW-1:0]  fall_cnt_reg;
  logic [CFG-1:0] cfg_sck_reg;
  logic           acq_tog_reg;
  logic           sdo_reg;
  logic [W-1:0]   result_reg;

  wire logic          cfg_take  = rise_cnt_reg < FW'(CFG);
  wire logic [FW-1:0] rise_next = rise_cnt_reg + FW'(1);
  wire logic [FW-1:0] fall_next = fall_cnt_reg + FW'(1);
  wire logic          acq_edge  = fall_cnt_reg == FW'(`MSAC_ACQ_EDGE - 1);
  wire logic [3:0]    out_idx   = 4'(W - 1) - 4'(fall_next);

  always_ff @(posedge i_sck or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rise_cnt_reg <= '0;
    else
      rise_cnt_reg <= rise_next;
  end

  // Bits land in place so the upper ones stay still after bit six
  always_ff @(posedge i_sck or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cfg_sck_reg <= `MSAC_CFG_RST;
    else if (cfg_take)
      cfg_sck_reg[3'(CFG - 1) - 3'(rise_cnt_reg)] <= i_serial_config_in;
  end

  always_ff @(negedge i_sck or negedge i_rst_n)
  begin
    if (!i_rst_n)
      fall_cnt_reg <= '0;
    else
      fall_cnt_reg <= fall_next;
  end

  always_ff @(negedge i_sck or negedge i_rst_n)
  begin
    if (!i_rst_n)
      acq_tog_reg <= 1'b0;
    else if (acq_edge)
      acq_tog_reg <= ~acq_tog_reg;
  end

  // Result is quasi-static: it only moves while busy, when the host is idle
  always_ff @(negedge i_sck or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sdo_reg <= 1'b0;
    else
      sdo_reg <= result_reg[out_idx];
  end

  // MSB is shown before any shift edge once a conversion ends
  assign o_serial_result_out = (fall_cnt_reg == '0) ? result_reg[W-1] : sdo_reg;

  // ---------------- System clock domain ----------------
  logic                 acq_sync;
  logic                 strb_sync;
  logic                 cmp_sync;
  logic                 rd_n_sync;
  logic                 acq_seen_reg;
  logic                 strb_q_reg;
  logic                 busy_n_reg;
  logic                 track_reg;
  logic                 oe_reg;
  logic [CFG-1:0]       cfg_reg;
  msac_pkg::msac_state_t state_reg;
  msac_pkg::msac_state_t state_next;

  // Strobe edge is caught on the pin itself so a pulse shorter than i_clk is not lost
  logic strb_tog_reg;
  always_ff @(posedge i_conversion_start_strobe or negedge i_rst_n)
  begin
    if (!i_rst_n)
      strb_tog_reg <= 1'b0;
    else
      strb_tog_reg <= ~strb_tog_reg;
  end

  msac_sync #(
    .W   (4),
    .RST (4'h1)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({acq_tog_reg, strb_tog_reg, i_comparator, i_read_n}),
    .o_q     ({acq_sync, strb_sync, cmp_sync, rd_n_sync})
  );

  msac_sar_if sar ();

  msac_sar #(
    .RES     (RES),
    .BIT_CYC (BIT_CYC)
  ) u_sar (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .s       (sar.eng)
  );

  wire logic         acq_evt   = acq_sync ^ acq_seen_reg;
  wire logic         start_evt = strb_sync ^ strb_q_reg;
  wire logic         in_conv   = state_reg == msac_pkg::st_conv;
  wire logic         unipolar_select       = cfg_reg[`MSAC_CFG_UNI];
  wire logic [W-1:0] low_mask  = ~({W{1'b1}} << (W - RES));
  // Comparator output is offset binary; bipolar flips the sign bit
  wire logic [W-1:0] code      = {sar.result[W-1] ^ ~unipolar_select, sar.result[W-2:0]};

  assign sar.start  = start_evt && !in_conv;
  assign sar.decide = cmp_sync;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      msac_pkg::st_idle:
        if (start_evt)
          state_next = msac_pkg::st_conv;
        else if (acq_evt)
          state_next = msac_pkg::st_acq;
      msac_pkg::st_acq:
        if (start_evt)
          state_next = msac_pkg::st_conv;
      msac_pkg::st_conv:
        if (sar.done)
          state_next = msac_pkg::st_idle;
      default:
        state_next = msac_pkg::st_idle;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_reg <= msac_pkg::st_idle;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      acq_seen_reg <= 1'b0;
      strb_q_reg   <= 1'b0;
    end
    else
    begin
      acq_seen_reg <= acq_sync;
      strb_q_reg   <= strb_sync;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      busy_n_reg <= 1'b1;
      track_reg  <= 1'b0;
    end
    else
    begin
      busy_n_reg <= state_next != msac_pkg::st_conv;
      track_reg  <= state_next == msac_pkg::st_acq;
    end
  end

  // Mux and span settle for sampling; power bits are final at the strobe
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cfg_reg <= `MSAC_CFG_RST;
    else if (acq_evt && !in_conv)
      cfg_reg[CFG-1:`MSAC_CFG_SPAN] <= cfg_sck_reg[CFG-1:`MSAC_CFG_SPAN];
    else if (sar.start)
      cfg_reg[`MSAC_CFG_NAP:0] <= cfg_sck_reg[`MSAC_CFG_NAP:0];
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      result_reg <= `MSAC_RESULT_RST;
    else if (sar.done)
      result_reg <= code & ~low_mask;
  end

  // Output floats while read is high, so a tied strobe also floats it
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      oe_reg <= 1'b0;
    else
      oe_reg <= !rd_n_sync;
  end

  assign o_serial_result_out_oe = oe_reg;
  assign o_busy_n               = busy_n_reg;
  assign o_sample_hold_track    = track_reg;
  assign o_dac_trial            = sar.trial;
  assign o_mux_single_ended     = cfg_reg[`MSAC_CFG_SGL];
  assign o_mux_odd_sign         = cfg_reg[`MSAC_CFG_ODD];
  assign o_mux_select           = cfg_reg[`MSAC_CFG_SEL +: 2];
  assign o_unipolar_select      = unipolar_select;
  assign o_span_double          = cfg_reg[`MSAC_CFG_SPAN];
  assign o_nap_req              = cfg_reg[`MSAC_CFG_NAP];
  assign o_sleep_req            = cfg_reg[`MSAC_CFG_SLEEP];

  // ---------------- Checks ----------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  logic [7:0] busy_cyc_reg;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      busy_cyc_reg <= '0;
    else if (o_busy_n)
      busy_cyc_reg <= '0;
    else
      busy_cyc_reg <= busy_cyc_reg + 8'h01;
  end

  a_busy_on_start: assert property (sar.start |=> !o_busy_n && !o_sample_hold_track)
    else $error("busy or hold missing after a start strobe");
  a_conv_time: assert property ($rose(o_busy_n) |-> busy_cyc_reg == 8'(CONV_LO))
    else $error("conversion length is wrong");
  a_busy_low_conv: assert property (!o_busy_n && !sar.done |=> !o_busy_n)
    else $error("busy returned high before the conversion ended");
  a_start_ignored: assert property (in_conv && start_evt && !sar.done |=> in_conv ##0 !o_busy_n)
    else $error("start strobe disturbed a running conversion");
  a_result_load: assert property (sar.done |=> result_reg == ($past(code) & ~low_mask) ##1 o_busy_n)
    else $error("result not loaded at end of conversion");
  a_tail_zero: assert property ((result_reg & low_mask) == '0)
    else $error("bits below the resolution are not zero");
  a_bipolar_sign: assert property (sar.done && !unipolar_select |=> result_reg[W-1] != $past(sar.result[W-1]))
    else $error("bipolar result is not two's complement");
  a_acq_on_sixth: assert property (acq_evt && state_reg == msac_pkg::st_idle && !start_evt |=> ##1 o_sample_hold_track)
    else $error("acquisition did not start");
  a_float_read: assert property (rd_n_sync |=> !o_serial_result_out_oe)
    else $error("output driven while read is high");
  a_cfg_frozen: assert property (@(posedge i_sck) disable iff (!i_rst_n)
    !cfg_take |=> $stable(cfg_sck_reg))
    else $error("configuration changed after the eighth bit");

  c_conv_done: cover property (sar.start ##[1:200] sar.done);
  c_start_ignored: cover property (in_conv && start_evt);
  c_acq_then_conv: cover property (state_reg == msac_pkg::st_acq ##1 in_conv);
endmodule
`default_nettype wire

// >>> msac_host_model.sv
// Host model: shifts configuration frames and drives strobe and read enable
`timescale 1ns/1ps
`default_nettype none
module msac_host_model (
  // Link
  output logic      o_sck,
  output logic      o_serial_config_in,
  input  wire logic i_serial_result_out,
  // Control
  output logic      o_conversion_start_strobe,
  output logic      o_read_n
);
  logic mode2;
  logic rd_low;

  assign o_read_n = mode2 ? o_conversion_start_strobe : !rd_low;

  initial
  begin
    o_sck = 1'h1;
    o_serial_config_in = 1'h0;
    o_conversion_start_strobe = 1'h0;
    mode2 = 1'h0;
    rd_low = 1'h0;
  end

  task automatic set_mode(input logic m2, input logic low);
    mode2 = m2;
    rd_low = low;
  endtask

  task automatic set_strobe(input logic v);
    o_conversion_start_strobe = v;
  endtask

  // Shift clock stands high between frames; data moves on falling edges
  task automatic frame(input logic [7:0] cfg, output logic [15:0] res);
    res[15] = i_serial_result_out;
    for (int k = 1; k <= 16; k++)
    begin
      o_sck = 1'h0;
      // Past the word the line toggles, so late capture would corrupt nap and sleep
      o_serial_config_in = (k <= 8) ? cfg[8-k] : k[0];
      #16;
      o_sck = 1'h1;
      if (k < 16)
        res[15-k] = i_serial_result_out;
      #16;
      // Stretch before the sixth fall so an early acquisition start shows
      if (k == 5)
        #400;
    end
    o_serial_config_in = ~o_serial_config_in;
  endtask
endmodule
`default_nettype wire

// >>> msac_top_tb_top.sv
// Self-checking bench for the SAR ADC control block
`timescale 1ns/1ps
`default_nettype none
module msac_top_tb_top;
  logic        clk, rst_n, sck, serial_config_in, strb, rd_n, serial_result_out, sdo_oe, busy_n, comp, track;
  logic        sgl, odd, unipolar_select, span, nap, sleep, sdo_line;
  logic [1:0]  sel;
  logic [15:0] dac, vin, e, tail_res;
  int          num_errors;
  int          num_checks;

  // Comparator keeps the trial bit while the input is at or above it
  assign comp = (vin >= dac);
  // Released output shows the inverse level, never a stale valid bit
  assign sdo_line = sdo_oe ? serial_result_out : ~serial_result_out;

  always #25 clk = ~clk;

  msac_top #(.RES(16)) uut (
    .i_clk                     (clk),
    .i_rst_n                   (rst_n),
    .i_sck                     (sck),
    .i_serial_config_in        (serial_config_in),
    .i_conversion_start_strobe (strb),
    .i_read_n                  (rd_n),
    .o_serial_result_out       (serial_result_out),
    .o_serial_result_out_oe    (sdo_oe),
    .o_busy_n                  (busy_n),
    .i_comparator              (comp),
    .o_dac_trial               (dac),
    .o_sample_hold_track       (track),
    .o_mux_single_ended        (sgl),
    .o_mux_odd_sign            (odd),
    .o_mux_select              (sel),
    .o_unipolar_select         (unipolar_select),
    .o_span_double             (span),
    .o_nap_req                 (nap),
    .o_sleep_req               (sleep)
  );

  msac_host_model host (
    .o_sck                     (sck),
    .o_serial_config_in        (serial_config_in),
    .i_serial_result_out       (sdo_line),
    .o_conversion_start_strobe (strb),
    .o_read_n                  (rd_n)
  );

  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp1(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic reset_values();
    tick(1);
    cmp1(busy_n, 1'h1, "busy idle");
    cmp1(sdo_oe, 1'h0, "oe in reset");
    cmp1(track, 1'h0, "track in reset");
    cmp16({8'h00, sgl, odd, sel, unipolar_select, span, nap, sleep}, 16'h0000, "config outs");
    cmp16(dac, 16'h0000, "trial in reset");
  endtask

  task automatic read_mode1();
    host.set_mode(1'h0, 1'h1);
    tick(2);
    cmp1(sdo_oe, 1'h0, "oe too early");
    tick(1);
    cmp1(sdo_oe, 1'h1, "oe with read low");
  endtask

  // One frame, acquisition, conversion with a stray strobe; returns next expected code
  task automatic cycle(input logic [7:0] cfg, input logic [15:0] v,
                       input logic [15:0] prev, output logic [15:0] nxt);
    logic [15:0] res;
    int          fall;
    int          lows;
    realtime     t0;
    realtime     tr;
    fall = 0;
    lows = 0;
    t0 = $realtime;
    tr = t0;
    cmp1(track, 1'h0, "track before word");
    fork
      host.frame(cfg, res);
      begin
        #510;
        cmp1(track, 1'h0, "track before sixth fall");
      end
    join
    cmp16(res, prev, "previous result");
    tick(1);
    cmp1(track, 1'h1, "track after word");
    cmp16({10'h000, sgl, odd, sel, unipolar_select, span}, {10'h000, cfg[7:2]}, "mux and range");
    vin = v;
    tick(80);  // Host allows 4 us of acquisition
    host.set_strobe(1'h1);  // Held 250 ns, above the minimum
    for (int n = 1; n <= 120; n++)
    begin
      tick(1);
      if (n == 5 || n == 33)
        host.set_strobe(1'h0);
      if (n == 30)
        host.set_strobe(1'h1);
      if (n == 4)
        cmp1(sdo_oe, !host.mode2, "oe while strobe high");
      if (busy_n === 1'h0)
      begin
        lows++;
        tr = $realtime;
      end
      if (busy_n === 1'h0 && fall == 0)
      begin
        fall = n;
        cmp1(track, 1'h0, "hold at start");
        cmp16(dac, 16'h8000, "first trial");
        cmp16({14'h0000, nap, sleep}, {14'h0000, cfg[1:0]}, "power requests");
      end
    end
    cmp16(16'(fall), 16'h0003, "busy fall delay");
    cmp16(16'(lows), 16'h0051, "busy low cycles");
    cmp1(sdo_oe, 1'h1, "oe after busy");
    cmp1((tr - t0) < 10000.0, 1'h1, "cycle time");
    nxt = cfg[3] ? v : {~v[15], v[14:0]};
  endtask

  initial
  begin
    #200000;
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    clk = 1'h0;
    rst_n = 1'h0;
    vin = 16'h0000;
    e = 16'h0000;
    num_errors = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    #2 rst_n = 1'h1;
    reset_values();
    read_mode1();
    cycle(8'ha6, 16'h1234, e, e);
    cycle(8'h5b, 16'hc3a5, e, e);
    host.set_mode(1'h1, 1'h0);
    cycle(8'h1c, 16'hffff, e, e);
    cycle(8'hf1, 16'h0000, e, e);
    cycle(8'h00, 16'h7ffe, e, e);
    host.frame(8'h00, tail_res);
    cmp16(tail_res, e, "last result");
    tally_and_finish();
  end
endmodule
`default_nettype wire
